// ===== mtf_pkg.sv
package mtf_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD  = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [2:0] A_VALHI = 3'h1;  // Values at 0x20..0x3C
  // Control field positions
  localparam int F_HDR = 0;
  localparam int F_BLK = 1;
  localparam int F_SEP = 3;
  localparam int F_FUN = 5;
  localparam int F_PRI = 7;
  localparam int F_SEC = 11;
  localparam int F_RES = 13;
  localparam int F_DP  = 15;
  localparam int F_EXP = 18;
  localparam int F_CMP = 20;
  localparam int F_NEG = 22;
  localparam int F_OVR = 23;
  localparam int F_ERR = 24;
  localparam int CTRL_W = 25;
  localparam logic [CTRL_W-1:0] CTRL_RST = 25'h000001F;  // Header on
  // Encodings
  localparam logic [1:0] BLK_CRLF = 2'h0;
  localparam logic [1:0] BLK_LF   = 2'h1;
  localparam logic [1:0] BLK_EOI  = 2'h2;
  localparam logic [1:0] SEP_COMMA = 2'h0;
  localparam logic [1:0] SEP_SPACE = 2'h1;
  localparam logic [1:0] SEC_CMP1 = 2'h1;
  localparam logic [1:0] SEC_STAT = 2'h3;
  localparam logic [1:0] CMP_HIGH = 2'h1;
  localparam logic [1:0] CMP_LOW  = 2'h2;
  localparam logic [1:0] FUN_OHM  = 2'h2;  // Codes at or above: resistance
  localparam logic [3:0] PRI_MAX  = 4'h8;
  // ASCII characters
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_H     = 8'h48;
  localparam logic [7:0] CH_L     = 8'h4C;
  localparam logic [7:0] CH_P     = 8'h50;
  localparam logic [7:0] CH_O     = 8'h4F;
  localparam logic [7:0] CH_ERR   = 8'h45;
  // Character tables, first character in the top byte
  localparam logic [63:0] FUN_STR  = "DVVLR RL";
  localparam logic [71:0] PRI_STR  = " SPDMBRWT";
  localparam logic [63:0] STAT_STR = "CXNAKSYZ";
  localparam logic [95:0] EXP_STR  = "-06-03+00+03";
  localparam logic [23:0] EXP_BIG  = "+19";
  // Field lengths and counts
  localparam logic [3:0] DIG_MIN  = 4'h5;  // 4-1/2 digit resolution
  localparam logic [3:0] SMP_DIG  = 4'h5;
  localparam logic [3:0] HDR_LEN  = 4'h4;
  localparam logic [3:0] EXP_LEN  = 4'h4;
  localparam logic [2:0] LAST_REC = 3'h7;
  localparam int VAL_W = 28;
  // Output phase, Gray coded along the record
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_HDR   = 3'b001,
    PH_SIGN  = 3'b011,
    PH_MANT  = 3'b010,
    PH_EXP   = 3'b110,
    PH_DELIM = 3'b111
  } mtf_phase_e;
endpackage

// ===== mtf_talker_formatter.sv
`timescale 1ns/1ps
module mtf_talker_formatter (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dataReady,
  output logic      [7:0]  dataOut,
  output logic             dataValid,
  output logic             eoi
);
  // Register selector codes
  localparam logic [2:0] S_NONE = 3'h0;
  localparam logic [2:0] S_CTRL = 3'h1;
  localparam logic [2:0] S_CMD  = 3'h2;
  localparam logic [2:0] S_STAT = 3'h3;
  localparam logic [2:0] S_VAL  = 3'h4;

  logic [mtf_pkg::CTRL_W-1:0] ctrl;        // Format control
  logic [mtf_pkg::VAL_W-1:0]  val [8];     // BCD values per record
  mtf_pkg::mtf_phase_e        phase;       // Field being sent
  mtf_pkg::mtf_phase_e        next_phase;  // Field after this one
  logic [3:0]                 pos;         // Byte within field
  logic [2:0]                 rec;         // Record within data set
  logic [7:0]                 bytesSent;   // Bytes of current set
  logic [7:0]                 curByte;     // Byte to present next
  logic                       eoiNow;      // Flag goes with curByte
  logic                       lastByte;    // Final byte of field
  logic [3:0]                 fieldLen;    // Bytes in this field
  logic [3:0]                 delimLen;    // Bytes of delimiter
  logic [3:0]                 nDig;        // Mantissa digits
  logic [3:0]                 dpPos;       // Point position
  logic [3:0]                 digIdx;      // Digit counted from left
  logic [3:0]                 nib;         // Selected BCD digit
  logic                       isStat;      // Statistics set active
  logic                       smpRec;      // Sample-size record
  logic                       lastRec;     // Record closes the set
  logic                       bad;         // Overscale or error
  logic                       adv;         // Byte loaded this cycle
  logic                       busy;        // Set being sent
  logic                       setup;       // APB setup cycle
  logic                       access;      // APB access completes
  logic [2:0]                 sel;         // Decoded register

  // Decodes an APB byte address into a register selector
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    if (a == mtf_pkg::A_CTRL)
      reg_sel = S_CTRL;
    else if (a == mtf_pkg::A_CMD)
      reg_sel = S_CMD;
    else if (a == mtf_pkg::A_STAT)
      reg_sel = S_STAT;
    else if (a[7:5] == mtf_pkg::A_VALHI && a[1:0] == 2'h0)
      reg_sel = S_VAL;
    else
      reg_sel = S_NONE;
  endfunction

  // Field views of control
  assign isStat  = ctrl[mtf_pkg::F_SEC +: 2] == mtf_pkg::SEC_STAT;
  assign smpRec  = isStat && rec == 3'h0;
  assign lastRec = !isStat || rec == mtf_pkg::LAST_REC;
  assign bad     = ctrl[mtf_pkg::F_OVR] || ctrl[mtf_pkg::F_ERR];
  assign nDig    = mtf_pkg::DIG_MIN + {2'h0, ctrl[mtf_pkg::F_RES +: 2]};
  assign dpPos   = bad ? nDig : {1'b0, ctrl[mtf_pkg::F_DP +: 3]};
  assign busy    = phase != mtf_pkg::PH_IDLE;
  assign adv     = busy && (!dataValid || dataReady);
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign sel     = reg_sel(paddr);

  // Delimiter length: separator inside a statistics set, else block form
  always_comb
  begin
    if (isStat && !lastRec)
      delimLen = (ctrl[mtf_pkg::F_SEP +: 2] > mtf_pkg::SEP_SPACE)
               ? 4'h2 : 4'h1;
    else if (ctrl[mtf_pkg::F_BLK +: 2] == mtf_pkg::BLK_CRLF)
      delimLen = 4'h2;
    else if (ctrl[mtf_pkg::F_BLK +: 2] == mtf_pkg::BLK_LF)
      delimLen = 4'h1;
    else
      delimLen = 4'h0;
  end

  // Picks the mantissa digit under the current position
  always_comb
  begin
    digIdx = (pos < dpPos) ? pos : pos - 4'h1;
    if (smpRec)
      nib = 4'(val[0] >> {mtf_pkg::SMP_DIG - 4'h1 - pos, 2'h0});
    else
      nib = 4'(val[rec] >> {nDig - 4'h1 - digIdx, 2'h0});
  end

  // Builds the ASCII byte for the current field and position
  always_comb
  begin
    curByte  = mtf_pkg::CH_SP;
    fieldLen = 4'h1;
    unique case (phase)
      mtf_pkg::PH_HDR:
      begin
        fieldLen = mtf_pkg::HDR_LEN;
        if (pos < 4'h2)
          curByte = mtf_pkg::FUN_STR[8 * (7 - (2 * ctrl[mtf_pkg::F_FUN +: 2]
                    + pos)) +: 8];
        else if (pos == 4'h2)
        begin
          if (ctrl[mtf_pkg::F_OVR])
            curByte = mtf_pkg::CH_O;
          else if (ctrl[mtf_pkg::F_ERR])
            curByte = mtf_pkg::CH_ERR;
          else if (ctrl[mtf_pkg::F_PRI +: 4] <= mtf_pkg::PRI_MAX)
            curByte = mtf_pkg::PRI_STR[8 * (8 - ctrl[mtf_pkg::F_PRI +: 4])
                      +: 8];
        end
        else if (isStat)
          curByte = mtf_pkg::STAT_STR[8 * (7 - rec) +: 8];
        else if (ctrl[mtf_pkg::F_SEC +: 2] != 2'h0)
        begin
          // H and L alike under both comparator settings; P only when the field is 2
          if (ctrl[mtf_pkg::F_CMP +: 2] == mtf_pkg::CMP_HIGH)
            curByte = mtf_pkg::CH_H;
          else if (ctrl[mtf_pkg::F_CMP +: 2] == mtf_pkg::CMP_LOW)
            curByte = mtf_pkg::CH_L;
          else if (ctrl[mtf_pkg::F_SEC +: 2] != mtf_pkg::SEC_CMP1)
            curByte = mtf_pkg::CH_P;
        end
      end
      mtf_pkg::PH_SIGN:
      begin
        // Resistance and error records carry a space
        if (ctrl[mtf_pkg::F_FUN +: 2] >= mtf_pkg::FUN_OHM
            || ctrl[mtf_pkg::F_ERR])
          curByte = mtf_pkg::CH_SP;
        else if (ctrl[mtf_pkg::F_NEG])
          curByte = mtf_pkg::CH_MINUS;
        else
          curByte = mtf_pkg::CH_PLUS;
      end
      mtf_pkg::PH_MANT:
      begin
        fieldLen = smpRec ? mtf_pkg::SMP_DIG : nDig + 4'h1;
        if (!smpRec && pos == dpPos)
          curByte = mtf_pkg::CH_DOT;
        else if (bad && !smpRec)
          curByte = mtf_pkg::CH_9;
        else
          curByte = mtf_pkg::CH_0 + {4'h0, nib};
      end
      mtf_pkg::PH_EXP:
      begin
        fieldLen = mtf_pkg::EXP_LEN;
        if (pos == 4'h0)
          curByte = mtf_pkg::CH_E;
        else if (bad)
          curByte = mtf_pkg::EXP_BIG[8 * (3 - pos) +: 8];
        else
          curByte = mtf_pkg::EXP_STR[8 * (12 - 3 * ctrl[mtf_pkg::F_EXP +: 2]
                    - pos) +: 8];
      end
      mtf_pkg::PH_DELIM:
      begin
        fieldLen = delimLen;
        if (isStat && !lastRec)
        begin
          if (ctrl[mtf_pkg::F_SEP +: 2] == mtf_pkg::SEP_COMMA)
            curByte = mtf_pkg::CH_COMMA;
          else if (ctrl[mtf_pkg::F_SEP +: 2] == mtf_pkg::SEP_SPACE)
            curByte = mtf_pkg::CH_SP;
          else
            curByte = (pos == 4'h0) ? mtf_pkg::CH_CR : mtf_pkg::CH_LF;
        end
        else if (delimLen == 4'h2)
          curByte = (pos == 4'h0) ? mtf_pkg::CH_CR : mtf_pkg::CH_LF;
        else
          curByte = mtf_pkg::CH_LF;
      end
      mtf_pkg::PH_IDLE:
        curByte = mtf_pkg::CH_SP;
      default:
        curByte = mtf_pkg::CH_SP;
    endcase
  end

  // Field order and end-or-identify timing
  always_comb
  begin
    lastByte = pos == fieldLen - 4'h1;
    eoiNow = 1'b0;
    if (lastRec && ctrl[mtf_pkg::F_BLK +: 2] == mtf_pkg::BLK_CRLF)
      eoiNow = phase == mtf_pkg::PH_DELIM && pos == 4'h1;
    else if (lastRec && ctrl[mtf_pkg::F_BLK +: 2] == mtf_pkg::BLK_EOI)
      eoiNow = phase == mtf_pkg::PH_EXP && lastByte;
    unique case (phase)
      mtf_pkg::PH_HDR:
        next_phase = smpRec ? mtf_pkg::PH_MANT : mtf_pkg::PH_SIGN;
      mtf_pkg::PH_SIGN:
        next_phase = mtf_pkg::PH_MANT;
      mtf_pkg::PH_MANT:
        next_phase = smpRec ? mtf_pkg::PH_DELIM : mtf_pkg::PH_EXP;
      mtf_pkg::PH_EXP:
        next_phase = (delimLen == 4'h0) ? mtf_pkg::PH_IDLE
                   : mtf_pkg::PH_DELIM;
      mtf_pkg::PH_DELIM:
        next_phase = mtf_pkg::PH_IDLE;
      mtf_pkg::PH_IDLE:
        next_phase = mtf_pkg::PH_IDLE;
      default:
        next_phase = mtf_pkg::PH_IDLE;
    endcase
  end

  // Sequencer: start command, field and record stepping
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase <= mtf_pkg::PH_IDLE;
      pos   <= 4'h0;
      rec   <= 3'h0;
    end
    else if (!busy)
    begin
      if (access && pwrite && sel == S_CMD && pwdata[0])
      begin
        rec   <= 3'h0;
        pos   <= 4'h0;
        // Header off starts straight at the sign, or at the mantissa of a statistics set
        phase <= ctrl[mtf_pkg::F_HDR] ? mtf_pkg::PH_HDR
               : (isStat ? mtf_pkg::PH_MANT : mtf_pkg::PH_SIGN);
      end
    end
    else if (adv)
    begin
      if (!lastByte)
        pos <= pos + 4'h1;
      else if (next_phase != mtf_pkg::PH_IDLE)
      begin
        pos   <= 4'h0;
        phase <= next_phase;
      end
      else if (!lastRec)
      begin
        pos   <= 4'h0;
        rec   <= rec + 3'h1;
        phase <= ctrl[mtf_pkg::F_HDR] ? mtf_pkg::PH_HDR
               : mtf_pkg::PH_SIGN;
      end
      else
      begin
        pos   <= 4'h0;
        phase <= mtf_pkg::PH_IDLE;
      end
    end
  end

  // Output byte register, held until the listener takes it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dataOut   <= 8'h00;
      dataValid <= 1'b0;
      eoi       <= 1'b0;
    end
    else if (adv)
    begin
      dataOut   <= curByte;
      dataValid <= 1'b1;
      eoi       <= eoiNow;
    end
    else if (dataReady)
    begin
      dataValid <= 1'b0;
      eoi       <= 1'b0;
    end
  end

  // Byte count of the current set, flag line not counted
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bytesSent <= 8'h00;
    else if (!busy && access && pwrite && sel == S_CMD && pwdata[0])
      bytesSent <= 8'h00;
    else if (adv)
      bytesSent <= bytesSent + 8'h01;
  end

  // Register writes; format and values are locked while busy
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctrl <= mtf_pkg::CTRL_RST;
    else if (access && pwrite && !busy && sel == S_CTRL)
      ctrl <= pwdata[mtf_pkg::CTRL_W-1:0];
  end

  // Value memory, one BCD word per record
  always_ff @(posedge ref_clk)
  begin
    if (access && pwrite && !busy && sel == S_VAL)
      val[paddr[4:2]] <= pwdata[mtf_pkg::VAL_W-1:0];
  end

  // APB answer, ready in the first access cycle, no wait state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (setup)
    begin
      pready  <= 1'b1;
      pslverr <= sel == S_NONE
              || (pwrite && busy && (sel == S_CTRL || sel == S_VAL));
      prdata  <= 32'h00000000;
      if (!pwrite && sel == S_CTRL)
        prdata <= {7'h00, ctrl};
      else if (!pwrite && sel == S_STAT)
        prdata <= {16'h0000, bytesSent, 4'h0, rec, busy};
      else if (!pwrite && sel == S_VAL)
        prdata <= {4'h0, val[paddr[4:2]]};
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_hold;
    dataValid && !dataReady |=> dataValid && $stable(dataOut) && $stable(eoi);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");

  property p_crlf_eoi;
    eoi && ctrl[mtf_pkg::F_BLK +: 2] == mtf_pkg::BLK_CRLF
      |-> dataOut == mtf_pkg::CH_LF && dataValid;
  endproperty
  a_crlf_eoi: assert property (p_crlf_eoi) else $error("eoi place");

  property p_eoi_last;
    eoi && ctrl[mtf_pkg::F_BLK +: 2] == mtf_pkg::BLK_EOI
      |-> dataOut != mtf_pkg::CH_LF && dataOut != mtf_pkg::CH_CR;
  endproperty
  a_eoi_last: assert property (p_eoi_last) else $error("eoi form");

  property p_end;
    dataValid && eoi && dataReady |=> !busy;
  endproperty
  a_end: assert property (p_end) else $error("set not ended");

  property p_nohdr;
    !busy && access && pwrite && sel == S_CMD && pwdata[0]
      && !ctrl[mtf_pkg::F_HDR] |=> phase != mtf_pkg::PH_HDR;
  endproperty
  a_nohdr: assert property (p_nohdr) else $error("header sent");

  property p_sign;
    phase == mtf_pkg::PH_SIGN && ctrl[mtf_pkg::F_FUN +: 2] >= mtf_pkg::FUN_OHM
      |-> curByte == mtf_pkg::CH_SP;
  endproperty
  a_sign: assert property (p_sign) else $error("ohm sign");

  property p_big_exp;
    phase == mtf_pkg::PH_EXP && pos == 4'h2 && bad
      |-> curByte == 8'h31;
  endproperty
  a_big_exp: assert property (p_big_exp) else $error("exp not 19");

  property p_sep;
    phase == mtf_pkg::PH_DELIM && isStat && rec < mtf_pkg::LAST_REC
      && ctrl[mtf_pkg::F_SEP +: 2] == mtf_pkg::SEP_COMMA
      |-> curByte == mtf_pkg::CH_COMMA && !eoiNow;
  endproperty
  a_sep: assert property (p_sep) else $error("bad separator");

  property p_apb;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb timing");

  c_stat: cover property (isStat && rec == mtf_pkg::LAST_REC && eoi);
  c_ovr: cover property (phase == mtf_pkg::PH_EXP && ctrl[mtf_pkg::F_OVR]);
  c_eoi: cover property (eoi && ctrl[mtf_pkg::F_BLK +: 2] == mtf_pkg::BLK_EOI);
endmodule

// ===== mtf_listener_model.sv
`timescale 1ns/1ps
module mtf_listener_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataValid,
  input  wire logic       eoi,
  input  wire logic       stallMode,
  output logic            dataReady,
  output logic            gotByte,
  output logic      [7:0] gotData,
  output logic            gotEoi
);
  // Accepts bytes, stalling at random when asked; the end flag travels
  // beside the byte and is never counted as one
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dataReady <= 1'b0;
      gotByte   <= 1'b0;
    end
    else
    begin
      dataReady <= stallMode ? 1'($urandom % 2) : 1'b1;
      gotByte   <= dataValid & dataReady;
      gotData   <= dataOut;
      gotEoi    <= eoi;
    end
  end
endmodule

// ===== mtf_talker_formatter_tb.sv
`timescale 1ns/1ps
module mtf_talker_formatter_tb;
  logic        ref_clk;            // Bench clock
  logic        rst;                // Synchronous reset
  logic        psel, penable;      // Bus phase strobes
  logic        pwrite;             // Bus direction
  logic [7:0]  paddr;              // Bus address
  logic [31:0] pwdata, prdata;     // Bus data
  logic        pready, pslverr;    // Bus answer
  logic        dataReady, eoi;     // Link handshake and end flag
  logic        dataValid;          // Byte present
  logic [7:0]  dataOut, gotData;   // Byte sent and byte taken
  logic        gotByte, gotEoi;    // Listener capture
  logic        stallMode;          // Listener stalls at random
  logic [8:0]  expQ[$];            // Expected end flag and byte
  logic [8:0]  expNote;            // Oldest expected note
  logic [31:0] cfg, rd;            // Current control, last read
  logic        er;                 // Last bus error
  logic [27:0] vals[8];            // Values of the set
  int          errorCnt, checksDone, expCnt;

  always #12.5 ref_clk = ~ref_clk;

  mtf_talker_formatter dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dataReady(dataReady),
    .dataOut(dataOut), .dataValid(dataValid), .eoi(eoi)
  );

  mtf_listener_model lsn (
    .ref_clk(ref_clk), .rst(rst), .dataOut(dataOut),
    .dataValid(dataValid), .eoi(eoi), .stallMode(stallMode),
    .dataReady(dataReady), .gotByte(gotByte), .gotData(gotData),
    .gotEoi(gotEoi)
  );

  // Compare one value, count it
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checksDone++;
    if (got !== ex)
    begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      errorCnt++;
    end
  endtask

  // Report and end the run
  task giveVerdict;
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One bus transfer, held until the answer is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      errorCnt++;
      giveVerdict;
    end
  endtask

  // Packs the control fields
  function logic [31:0] mk(int hd, bk, sp, fn, pr, sc, rs, dp, ex, cm, ng,
                           ov, e);
    return {7'h00, 1'(e), 1'(ov), 1'(ng), 2'(cm), 2'(ex), 3'(dp), 2'(rs),
            2'(sc), 4'(pr), 2'(fn), 2'(sp), 2'(bk), 1'(hd)};
  endfunction

  // Random BCD value
  function logic [27:0] rbcd();
    logic [27:0] r;
    for (int k = 0; k < 7; k++)
      r[4*k +: 4] = 4'($urandom % 10);
    return r;
  endfunction

  // Note one expected byte
  task put(input logic [7:0] b, input logic e);
    expQ.push_back({e, b});
    expCnt++;
  endtask

  // Comparator or statistics code of the fourth header character
  function logic [7:0] zch(input int idx);
    case (cfg[12:11])
      2'h0: return " ";
      2'h1: return cfg[21:20] == 1 ? "H" : cfg[21:20] == 2 ? "L" : " ";
      2'h2: return cfg[21:20] == 1 ? "H" : cfg[21:20] == 2 ? "L" : "P";
      default: return mtf_pkg::STAT_STR[63-8*idx -: 8];
    endcase
  endfunction

  // Expected bytes of one record, without its delimiter
  task putRec(input int idx);
    int          nd, pt, i;
    logic        bad;
    logic [23:0] ex;
    nd  = 5 + cfg[14:13];
    bad = cfg[23] | cfg[24];
    pt  = bad ? nd : cfg[17:15];
    ex  = bad ? "+19" : mtf_pkg::EXP_STR[95-24*cfg[19:18] -: 24];
    if (cfg[0])
    begin
      put(mtf_pkg::FUN_STR[63-16*cfg[6:5] -: 8], 1'b0);
      put(mtf_pkg::FUN_STR[55-16*cfg[6:5] -: 8], 1'b0);
      put(cfg[24] ? "E" : cfg[23] ? "O"
          : mtf_pkg::PRI_STR[71-8*cfg[10:7] -: 8], 1'b0);
      put(zch(idx), 1'b0);
    end
    if (cfg[12:11] == 2'h3 && idx == 0)
    begin
      for (i = 4; i >= 0; i--)
        put("0" + vals[0][4*i +: 4], 1'b0);
      return;
    end
    put((cfg[24] || cfg[6:5] >= 2) ? " " : cfg[22] ? "-" : "+",
        1'b0);
    for (i = nd - 1; i >= 0; i--)
    begin
      put(bad ? "9" : "0" + vals[idx][4*i +: 4], 1'b0);
      if (nd - i == pt)
        put(".", 1'b0);
    end
    put("E", 1'b0);
    for (i = 0; i < 3; i++)
      put(ex[23-8*i -: 8], 1'b0);
  endtask

  // Separator between records, block delimiter after the last
  task putEnd(input logic last);
    logic [8:0] t;
    if (!last)
      case (cfg[4:3])
        2'h0: put(",", 1'b0);
        2'h1: put(" ", 1'b0);
        default:
        begin
          put(8'h0D, 1'b0);
          put(8'h0A, 1'b0);
        end
      endcase
    else
      case (cfg[2:1])
        2'h0:
        begin
          put(8'h0D, 1'b0);
          put(8'h0A, 1'b1);
        end
        2'h1: put(8'h0A, 1'b0);
        default:
        begin
          t = expQ.pop_back();
          expQ.push_back({1'b1, t[7:0]});
        end
      endcase
  endtask

  // Program, note expectations, start, wait for the set to drain
  task runSet(input logic [31:0] c, input logic stall, input logic poke);
    int i, n, recs;
    cfg = c;
    stallMode <= stall;
    expCnt = 0;
    recs = (c[12:11] == 2'h3) ? 8 : 1;
    for (i = 0; i < 8; i++)
      vals[i] = rbcd();
    apb(1'b1, 8'h00, c);
    chk("ctrl write error", 0, er);
    for (i = 0; i < 8; i++)
      apb(1'b1, 8'(8'h20 + 4*i), {4'h0, vals[i]});
    for (i = 0; i < recs; i++)
    begin
      putRec(i);
      putEnd(i == recs - 1);
    end
    apb(1'b1, 8'h04, 32'h00000001);
    if (poke)
    begin
      apb(1'b1, 8'h00, 32'h00000000);
      chk("busy write error", 1, er);
    end
    n = 0;
    while (expQ.size() > 0 && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    do
    begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 20);
    if (n >= 20 || expQ.size() > 0)
    begin
      errorCnt++;
      giveVerdict;
    end
    else
      chk("bytes sent", expCnt % 256, rd[15:8]);
  endtask

  // Takes the oldest note whenever the listener takes a byte
  always @(posedge ref_clk)
  begin
    if (gotByte === 1'b1)
    begin
      if (expQ.size() == 0)
        chk("extra byte", 0, 1);
      else
      begin
        expNote = expQ.pop_front();
        chk("byte", expNote[7:0], gotData);
        chk("eoi", expNote[8], gotEoi);
      end
    end
  end

  // Main sequence
  initial
  begin
    int p, rs;
    ref_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stallMode = 1'b0;
    errorCnt = 0;
    checksDone = 0;
    void'($urandom(78150));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset value, command read, unmapped place
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0000001F, rd);
    apb(1'b0, 8'h04, 32'h0);
    chk("cmd read", 0, rd);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped write error", 1, er);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped read error", 1, er);
    chk("unmapped read data", 0, rd);
    // Plain voltage record, line feed end
    runSet(mk(1, 1, 0, 0, 0, 0, 0, 2, 2, 0, 0, 0, 0), 1'b0, 1'b0);
    // Every primary code with random fields
    for (p = 0; p < 9; p++)
    begin
      rs = $urandom % 3;
      runSet(mk($urandom % 2, $urandom % 3, 0, $urandom % 4, p,
                $urandom % 3, rs, 1 + $urandom % (5 + rs), $urandom % 4,
                $urandom % 3, $urandom % 2, 0, 0), p[0], 1'b0);
    end
    // Overscale without header, then with sign kept
    runSet(mk(0, 2, 0, 3, 0, 0, 0, 1, 0, 0, 1, 1, 0), 1'b1, 1'b0);
    runSet(mk(1, 0, 0, 0, 3, 1, 1, 2, 1, 1, 1, 1, 0), 1'b0, 1'b0);
    // Computation error
    runSet(mk(1, 1, 0, 0, 8, 2, 2, 3, 1, 2, 1, 0, 1), 1'b1, 1'b0);
    // Statistics under every separator and block form
    for (p = 0; p < 3; p++)
      runSet(mk(p != 1, p, p, p, p, 3, p, 3, p, 0, 1, 0, 0), 1'b1,
             p == 0);
    giveVerdict;
  end
endmodule
